// ---- clock_switch.sv ----
`timescale 1ns/1ps
module clock_switch
  import pll_ctl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // source control
  input  wire logic sel,
  input  wire logic xtick,
  input  wire logic vtick,
  input  wire logic stop,
  // divided output
  output logic      clk_out
);
  switch_state_e state_q, state_d;
  logic          cur_q, cur_d;
  logic [1:0]    xcnt_q, xcnt_d;
  logic [1:0]    vcnt_q, vcnt_d;
  logic          out_d;

  always_comb begin
    state_d = state_q;
    cur_d   = cur_q;
    xcnt_d  = xcnt_q;
    vcnt_d  = vcnt_q;
    out_d   = clk_out;
    case (state_q)
      SW_RUN: begin
        // divide selected source by two for a clean duty cycle
        if ((cur_q && vtick) || (!cur_q && xtick)) begin
          out_d = ~clk_out;
        end
        if (sel != cur_q) begin
          state_d = SW_HOLD;
          xcnt_d  = '0;
          vcnt_d  = '0;
        end
      end
      SW_HOLD: begin
        // output held static until both sources are seen settling
        if (xtick && xcnt_q != SWITCH_TICKS) begin
          xcnt_d = xcnt_q + 2'h1;
        end
        if (vtick && vcnt_q != SWITCH_TICKS) begin
          vcnt_d = vcnt_q + 2'h1;
        end
        if (xcnt_q == SWITCH_TICKS && vcnt_q == SWITCH_TICKS) begin
          cur_d   = sel;
          state_d = SW_RUN;
        end
      end
      default: state_d = SW_RUN;
    endcase
    if (stop) begin
      out_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SW_RUN;
      cur_q   <= 1'b0;
      xcnt_q  <= '0;
      vcnt_q  <= '0;
      clk_out <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      xcnt_q  <= xcnt_d;
      vcnt_q  <= vcnt_d;
      clk_out <= out_d;
    end
  end
endmodule : clock_switch

// ---- pll_clock_control_logic.sv ----
`timescale 1ns/1ps
module pll_clock_control_logic
  import pll_ctl_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RESET,
  // apb slave
  input  wire logic       PSEL,
  input  wire logic       PENABLE,
  input  wire logic       PWRITE,
  input  wire logic [7:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic            PREADY,
  output logic            PSLVERR,
  // analog loop status and source clocks
  input  wire logic       LOCK_DETECT,
  input  wire logic       TRACK_DETECT,
  input  wire logic       VCO_CLK_IN,
  input  wire logic       XTAL_CLK_IN,
  // system mode inputs
  input  wire logic       STOP_REQ,
  input  wire logic       BREAK_ACTIVE,
  // analog loop control
  output logic            PLL_ENABLE,
  output logic            TRACK_MODE,
  output logic      [3:0] MULT_N,
  output logic      [3:0] VCO_RANGE,
  // clock and interrupt outputs
  output logic            CRYSTAL_CLK_OUT,
  output logic            BASE_CLK_OUT,
  output logic            PLL_IRQ
);
  // synchronised pins
  logic [5:0] pins_s;
  logic       lock_s, track_s, vco_s, xtal_s, stop_s, brk_s;

  sync2 #(.WIDTH(6)) pin_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   ({LOCK_DETECT, TRACK_DETECT, VCO_CLK_IN, XTAL_CLK_IN, STOP_REQ, BREAK_ACTIVE}),
    .q   (pins_s)
  );
  assign {lock_s, track_s, vco_s, xtal_s, stop_s, brk_s} = pins_s;

  // register state
  logic       ie_q, ie_d;
  logic       flag_q, flag_d;
  logic       on_q, on_d;
  logic       bcs_q, bcs_d;
  logic       auto_q, auto_d;
  logic       acq_man_q, acq_man_d;
  logic       xld_q, xld_d;
  logic [3:0] mul_q, mul_d;
  logic [3:0] vrs_q, vrs_d;
  logic       break_clear_enable_q, break_clear_enable_d;
  logic       lock_prev_q;
  logic       vco_prev_q, xtal_prev_q;
  logic       vtick, xtick;
  // bus state
  logic       wr_en, rd_en;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic       mapped;
  logic       ready_d, err_d;
  logic [31:0] prdata_d;
  // output next values
  logic       en_d, track_d, irq_d, xclk_d;
  logic [3:0] n_d;

  assign vtick = vco_s & ~vco_prev_q;
  assign xtick = xtal_s & ~xtal_prev_q;
  assign wdat  = PWDATA[7:0];
  // a write or read takes effect at the edge that completes the access
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_en = PSEL & PENABLE & PREADY & ~PWRITE;

  // read mux
  always_comb begin
    rdat   = 8'h00;
    mapped = 1'b1;
    case (PADDR)
      CTRL_ADDR: begin
        rdat[CTRL_IE_BIT]   = ie_q & auto_q;
        rdat[CTRL_FLAG_BIT] = flag_q & auto_q;
        rdat[CTRL_ON_BIT]   = on_q;
        rdat[CTRL_BCS_BIT]  = bcs_q;
        rdat[3:0]           = CTRL_LOW_BITS;
      end
      BANDWIDTH_ADDR: begin
        rdat[BW_AUTO_BIT]  = auto_q;
        rdat[BW_LOCK_BIT]  = auto_q & lock_s;
        rdat[BW_TRACK_BIT] = auto_q ? track_s : acq_man_q;
        rdat[BW_XLD_BIT]   = xld_q & bcs_q;
      end
      PROG_ADDR: begin
        rdat[PROG_MUL_LSB +: 4] = mul_q;
        rdat[PROG_VRS_LSB +: 4] = vrs_q;
      end
      BRKCTL_ADDR: begin
        rdat[BRK_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  // apb answer: ready one cycle after setup, data and error latched with it
  always_comb begin
    ready_d  = PSEL & ~PENABLE;
    err_d    = PSEL & ~PENABLE & ~mapped;
    prdata_d = PRDATA;
    if (PSEL && !PENABLE) begin
      prdata_d = {24'h000000, rdat};
    end
  end

  // register next values
  always_comb begin
    ie_d      = ie_q;
    flag_d    = flag_q;
    on_d      = on_q;
    bcs_d     = bcs_q;
    auto_d    = auto_q;
    acq_man_d = acq_man_q;
    xld_d     = xld_q;
    mul_d     = mul_q;
    vrs_d     = vrs_q;
    break_clear_enable_d    = break_clear_enable_q;

    if (wr_en && PADDR == CTRL_ADDR) begin
      if (auto_q) begin
        ie_d = wdat[CTRL_IE_BIT];
      end
      // pll cannot be switched off under the VCO source
      if (wdat[CTRL_ON_BIT] || !bcs_q) begin
        on_d = wdat[CTRL_ON_BIT];
      end
      // select checks the old on bit, so enable and select need two writes
      if (!wdat[CTRL_BCS_BIT]) begin
        bcs_d = 1'b0;
      end else if (on_q && vrs_q != 4'h0) begin
        bcs_d = 1'b1;
      end
    end

    if (wr_en && PADDR == BANDWIDTH_ADDR) begin
      auto_d = wdat[BW_AUTO_BIT];
      if (!auto_q) begin
        acq_man_d = wdat[BW_TRACK_BIT];
      end
      if (wdat[BW_XLD_BIT]) begin
        xld_d = 1'b1;
      end
    end

    if (wr_en && PADDR == PROG_ADDR && !on_q) begin
      mul_d = wdat[PROG_MUL_LSB +: 4];
      vrs_d = wdat[PROG_VRS_LSB +: 4];
    end

    if (wr_en && PADDR == BRKCTL_ADDR) begin
      break_clear_enable_d = wdat[BRK_BREAK_CLEAR_ENABLE_BIT];
    end

    // crystal edge during the detection window proves the reference alive
    if (xtick) begin
      xld_d = 1'b0;
    end
    if (!bcs_q) begin
      xld_d = 1'b0;
    end

    // zero range forces crystal source
    if (vrs_q == 4'h0) begin
      bcs_d = 1'b0;
    end
    if (stop_s) begin
      bcs_d = 1'b0;
    end

    // clear first so that a same-cycle toggle still leaves the flag set
    if (rd_en && PADDR == CTRL_ADDR && (!brk_s || break_clear_enable_q)) begin
      flag_d = 1'b0;
    end
    if (auto_q && lock_s != lock_prev_q) begin
      flag_d = 1'b1;
    end
    if (!auto_q) begin
      flag_d = 1'b0;
    end
  end

  // loop control outputs; no gating for wait, only stop idles the block
  always_comb begin
    en_d    = on_q & (vrs_q != 4'h0) & ~stop_s;
    track_d = auto_q ? track_s : acq_man_q;
    n_d     = (mul_q == 4'h0) ? 4'h1 : mul_q;
    irq_d   = flag_q & ie_q & auto_q & ~stop_s;
    xclk_d  = xtal_s & ~stop_s;
  end

  // source switch with stasis and divide-by-two
  clock_switch base_switch (
    .clk     (MCLK),
    .rst     (RESET),
    .sel     (bcs_q),
    .xtick   (xtick),
    .vtick   (vtick),
    .stop    (stop_s),
    .clk_out (BASE_CLK_OUT)
  );

  // bus answer; ready is never held off, so every access ends one cycle after setup
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= prdata_d;
      PREADY  <= ready_d;
      PSLVERR <= err_d;
    end
  end

  // edge history resets to the idle pin level, so no false toggle follows reset
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ie_q        <= 1'b0;
      flag_q      <= 1'b0;
      on_q        <= PLL_ON_RESET;
      bcs_q       <= 1'b0;
      auto_q      <= 1'b0;
      acq_man_q   <= 1'b0;
      xld_q       <= 1'b0;
      mul_q       <= MUL_RESET;
      vrs_q       <= VRS_RESET;
      break_clear_enable_q      <= 1'b0;
      lock_prev_q <= 1'b0;
      vco_prev_q  <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      ie_q        <= ie_d;
      flag_q      <= flag_d;
      on_q        <= on_d;
      bcs_q       <= bcs_d;
      auto_q      <= auto_d;
      acq_man_q   <= acq_man_d;
      xld_q       <= xld_d;
      mul_q       <= mul_d;
      vrs_q       <= vrs_d;
      break_clear_enable_q      <= break_clear_enable_d;
      lock_prev_q <= lock_s;
      vco_prev_q  <= vco_s;
      xtal_prev_q <= xtal_s;
    end
  end

  // loop, clock and interrupt outputs, each straight from a flop
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PLL_ENABLE      <= 1'b0;
      TRACK_MODE      <= 1'b0;
      MULT_N          <= MUL_RESET;
      VCO_RANGE       <= VRS_RESET;
      PLL_IRQ         <= 1'b0;
      CRYSTAL_CLK_OUT <= 1'b0;
    end else begin
      PLL_ENABLE      <= en_d;
      TRACK_MODE      <= track_d;
      MULT_N          <= n_d;
      VCO_RANGE       <= vrs_q;
      PLL_IRQ         <= irq_d;
      CRYSTAL_CLK_OUT <= xclk_d;
    end
  end
endmodule : pll_clock_control_logic

// ---- pll_clock_control_logic_assertions.sv ----
`timescale 1ns/1ps
module pll_clock_control_logic_assertions
  import pll_ctl_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RESET,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // mode and loop outputs
  input wire logic        STOP_REQ,
  input wire logic        PLL_ENABLE,
  input wire logic [3:0]  MULT_N,
  input wire logic [3:0]  VCO_RANGE,
  input wire logic        CRYSTAL_CLK_OUT,
  input wire logic        BASE_CLK_OUT,
  input wire logic        PLL_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic rd_ok;
  assign rd_ok = PREADY && !PWRITE && !PSLVERR;
  a_ready_pulse: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after setup");
  a_unmapped_err: assert property (PSEL && !PENABLE
    && (PADDR > BRKCTL_ADDR || PADDR[1:0] != 2'h0) |=> PSLVERR)
    else $error("unmapped access without error");
  a_ctrl_low_ones: assert property (rd_ok && PADDR == CTRL_ADDR |-> PRDATA[3:0] == 4'hf)
    else $error("control low bits not ones");
  a_lock_manual: assert property (rd_ok && PADDR == BANDWIDTH_ADDR
    && !PRDATA[BW_AUTO_BIT] |-> !PRDATA[BW_LOCK_BIT])
    else $error("settled flag set in manual");
  a_mult_nonzero: assert property (MULT_N != 4'h0)
    else $error("multiplier zero");
  a_mult_locked: assert property (PLL_ENABLE |=> $stable(MULT_N))
    else $error("multiplier changed while on");
  a_range_locked: assert property (PLL_ENABLE |=> $stable(VCO_RANGE))
    else $error("range changed while on");
  a_zero_range: assert property (VCO_RANGE == 4'h0 |-> !PLL_ENABLE)
    else $error("loop enabled with zero range");
  a_stop_quiet: assert property (STOP_REQ [*5] |-> !PLL_IRQ && !BASE_CLK_OUT
    && !CRYSTAL_CLK_OUT)
    else $error("outputs active in stop");
  c_ctrl_read: cover property (rd_ok && PADDR == CTRL_ADDR);
  c_irq: cover property ($rose(PLL_IRQ));
  c_stop: cover property (STOP_REQ [*5]);
endmodule : pll_clock_control_logic_assertions

// ---- pll_ctl_pkg.sv ----
package pll_ctl_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] BANDWIDTH_ADDR = 8'h04;
  localparam logic [7:0] PROG_ADDR      = 8'h08;
  localparam logic [7:0] BRKCTL_ADDR    = 8'h0c;

  // pll_control_reg fields
  localparam int CTRL_IE_BIT   = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_ON_BIT   = 5;
  localparam int CTRL_BCS_BIT  = 4;
  localparam logic [3:0] CTRL_LOW_BITS = 4'hf;

  // pll_bandwidth_control fields
  localparam int BW_AUTO_BIT  = 7;
  localparam int BW_LOCK_BIT  = 6;
  localparam int BW_TRACK_BIT = 5;
  localparam int BW_XLD_BIT   = 4;

  // pll_multiplier_programming fields
  localparam int PROG_MUL_LSB = 4;
  localparam int PROG_VRS_LSB = 0;

  // break_flag_control_reg fields
  localparam int BRK_BREAK_CLEAR_ENABLE_BIT = 7;

  // reset values
  localparam logic       PLL_ON_RESET = 1'b1;
  localparam logic [3:0] MUL_RESET    = 4'h6;
  localparam logic [3:0] VRS_RESET    = 4'h6;

  // clock switch stasis: cycles of each source clock to wait
  localparam logic [1:0] SWITCH_TICKS = 2'h3;

  typedef enum logic [0:0] {
    SW_RUN  = 1'b0,
    SW_HOLD = 1'b1
  } switch_state_e;

endpackage : pll_ctl_pkg

// ---- sync2.sv ----
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // level crossing
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync2

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import pll_ctl_pkg::*;
  logic MCLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic LOCK_DETECT = 1'b0, TRACK_DETECT = 1'b0, XTAL_CLK_IN = 1'b0, VCO_CLK_IN = 1'b0;
  logic        xtal_run = 1'b0;
  logic [1:0]  xdiv = 2'h0, vdiv = 2'h0;
  logic STOP_REQ = 1'b0, BREAK_ACTIVE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, PLL_ENABLE, TRACK_MODE, CRYSTAL_CLK_OUT, BASE_CLK_OUT, PLL_IRQ;
  logic [3:0]  MULT_N, VCO_RANGE;
  logic [7:0]  r;
  logic        err;
  int          n_mismatch = 0;
  int          checks = 0;
  always #25 MCLK = ~MCLK;
  // source clocks slow enough for the pin synchronisers: vco period 4, crystal period 6
  always @(posedge MCLK) begin
    vdiv <= (vdiv == 2'h1) ? 2'h0 : vdiv + 2'h1;
    xdiv <= (xdiv == 2'h2) ? 2'h0 : xdiv + 2'h1;
    if (vdiv == 2'h1) begin
      VCO_CLK_IN <= ~VCO_CLK_IN;
    end
    if (!xtal_run) begin
      XTAL_CLK_IN <= 1'b0;
    end else if (xdiv == 2'h2) begin
      XTAL_CLK_IN <= ~XTAL_CLK_IN;
    end
  end
  pll_clock_control_logic pll_clock_control_logic_i (
    .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LOCK_DETECT(LOCK_DETECT), .TRACK_DETECT(TRACK_DETECT), .VCO_CLK_IN(VCO_CLK_IN),
    .XTAL_CLK_IN(XTAL_CLK_IN), .STOP_REQ(STOP_REQ), .BREAK_ACTIVE(BREAK_ACTIVE),
    .PLL_ENABLE(PLL_ENABLE), .TRACK_MODE(TRACK_MODE), .MULT_N(MULT_N),
    .VCO_RANGE(VCO_RANGE), .CRYSTAL_CLK_OUT(CRYSTAL_CLK_OUT),
    .BASE_CLK_OUT(BASE_CLK_OUT), .PLL_IRQ(PLL_IRQ));
  task cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask : cyc
  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  // request stands until ready is sampled high at a rising edge; only the watchdog ends a wait
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    err = PSLVERR;
    r   = PRDATA[7:0];
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp, input string s);
    apb(1'b0, a, 8'h00);
    chk(s, r, exp);
  endtask : rd
  task count_toggles(input int n, output int t);
    logic prev;
    t    = 0;
    prev = BASE_CLK_OUT;
    repeat (n) begin
      @(posedge MCLK);
      if (BASE_CLK_OUT !== prev) begin
        t++;
      end
      prev = BASE_CLK_OUT;
    end
  endtask : count_toggles
  task t_reset;
    rd(CTRL_ADDR, 8'h2f, "ctrl");
    rd(BANDWIDTH_ADDR, 8'h00, "bw");
    rd(PROG_ADDR, 8'h66, "prog");
    rd(8'h10, 8'h00, "unmapped");
    chk("slverr", {7'h0, err}, 8'h01);
  endtask : t_reset
  task t_prog;
    wr(CTRL_ADDR, 8'h0f);
    wr(PROG_ADDR, 8'h00);
    cyc(2);
    chk("mult", {4'h0, MULT_N}, 8'h01);
    chk("range", {4'h0, VCO_RANGE}, 8'h00);
    wr(BANDWIDTH_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h20);
    wr(CTRL_ADDR, 8'h30);
    cyc(2);
    chk("enable", {7'h0, PLL_ENABLE}, 8'h00);
    rd(CTRL_ADDR, 8'h2f, "bcs range0");
    wr(CTRL_ADDR, 8'h0f);
    wr(PROG_ADDR, 8'h66);
    wr(CTRL_ADDR, 8'h30);
    rd(CTRL_ADDR, 8'h2f, "bcs one write");
    wr(CTRL_ADDR, 8'h30);
    rd(CTRL_ADDR, 8'h3f, "bcs");
    wr(PROG_ADDR, 8'h0a);
    rd(PROG_ADDR, 8'h66, "prog on");
  endtask : t_prog
  task t_xld;
    wr(BANDWIDTH_ADDR, 8'h10);
    cyc(24);
    rd(BANDWIDTH_ADDR, 8'h10, "xld lost");
    xtal_run <= 1'b1;
    wr(BANDWIDTH_ADDR, 8'h10);
    cyc(24);
    rd(BANDWIDTH_ADDR, 8'h00, "xld live");
    // crystal stopped, so only the deselect can keep the bit clear
    xtal_run <= 1'b0;
    wr(CTRL_ADDR, 8'h20);
    wr(BANDWIDTH_ADDR, 8'h10);
    rd(BANDWIDTH_ADDR, 8'h00, "xld bcs0");
  endtask : t_xld
  task t_switch;
    int t;
    xtal_run    <= 1'b1;
    LOCK_DETECT <= 1'b1;
    wr(BANDWIDTH_ADDR, 8'h80);
    cyc(40);
    rd(BANDWIDTH_ADDR, 8'hc0, "settled");
    count_toggles(24, t);
    chk("base xtal", t[7:0], 8'h04);
    wr(CTRL_ADDR, 8'h30);
    cyc(2);
    count_toggles(8, t);
    chk("base hold", t[7:0], 8'h00);
    cyc(24);
    count_toggles(16, t);
    chk("base vco", t[7:0], 8'h04);
    wr(CTRL_ADDR, 8'h20);
    wr(BANDWIDTH_ADDR, 8'h00);
    LOCK_DETECT <= 1'b0;
  endtask : t_switch
  task t_track;
    wr(BANDWIDTH_ADDR, 8'h20);
    cyc(2);
    chk("track", {7'h0, TRACK_MODE}, 8'h01);
    wr(BANDWIDTH_ADDR, 8'ha0);
    cyc(2);
    chk("track auto", {7'h0, TRACK_MODE}, 8'h00);
    rd(BANDWIDTH_ADDR, 8'h80, "bw auto");
    wr(BANDWIDTH_ADDR, 8'h80);
    wr(BANDWIDTH_ADDR, 8'h00);
    rd(BANDWIDTH_ADDR, 8'h20, "bw kept");
  endtask : t_track
  task t_flag;
    wr(BANDWIDTH_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'ha0);
    LOCK_DETECT <= 1'b1;
    cyc(6);
    chk("irq", {7'h0, PLL_IRQ}, 8'h01);
    rd(CTRL_ADDR, 8'hef, "flag");
    rd(CTRL_ADDR, 8'haf, "flag rd");
    BREAK_ACTIVE <= 1'b1;
    LOCK_DETECT <= 1'b0;
    cyc(6);
    rd(CTRL_ADDR, 8'hef, "brk");
    rd(CTRL_ADDR, 8'hef, "brk kept");
    wr(BRKCTL_ADDR, 8'h80);
    rd(CTRL_ADDR, 8'hef, "brk clr");
    BREAK_ACTIVE <= 1'b0;
    cyc(4);
    rd(CTRL_ADDR, 8'haf, "brk after");
    wr(BANDWIDTH_ADDR, 8'h00);
    LOCK_DETECT <= 1'b1;
    cyc(6);
    chk("irq man", {7'h0, PLL_IRQ}, 8'h00);
  endtask : t_flag
  task t_stop;
    wr(CTRL_ADDR, 8'h30);
    STOP_REQ <= 1'b1;
    cyc(8);
    chk("stop", {5'h0, BASE_CLK_OUT, CRYSTAL_CLK_OUT, PLL_ENABLE}, 8'h00);
    STOP_REQ <= 1'b0;
    cyc(4);
    apb(1'b0, CTRL_ADDR, 8'h00);
    chk("bcs stop", {7'h0, r[CTRL_BCS_BIT]}, 8'h00);
  endtask : t_stop
  initial begin
    cyc(3);
    RESET <= 1'b0;
    t_reset;
    t_prog;
    t_xld;
    t_switch;
    t_track;
    t_flag;
    t_stop;
    stop_test;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    n_mismatch++;
    stop_test;
  end
endmodule : tb_top
bind pll_clock_control_logic pll_clock_control_logic_assertions
  pll_clock_control_logic_assertions_i (
  .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .STOP_REQ(STOP_REQ), .PLL_ENABLE(PLL_ENABLE), .MULT_N(MULT_N), .VCO_RANGE(VCO_RANGE),
  .CRYSTAL_CLK_OUT(CRYSTAL_CLK_OUT), .BASE_CLK_OUT(BASE_CLK_OUT), .PLL_IRQ(PLL_IRQ));
